// >>> dic_pkg.sv
package dic_pkg;

    // Array geometry
    localparam int unsigned ENTRIES  = 64;
    localparam int unsigned IDX_W    = 6;
    localparam int unsigned TAG_W    = 25;

    // Fetch address fields
    localparam int unsigned IDX_LSB  = 2;
    localparam int unsigned IDX_MSB  = 7;
    localparam int unsigned TAG_LSB  = 8;
    localparam int unsigned WSEL_BIT = 1;

    // Control register bits
    localparam int unsigned CTRL_ENABLE_BIT  = 0;
    localparam int unsigned CTRL_FREEZE_BIT  = 1;
    localparam int unsigned CTRL_CLR_ONE_BIT = 2;
    localparam int unsigned CTRL_CLR_ALL_BIT = 3;

    // Line select register index field
    localparam int unsigned LSEL_IDX_LSB = 2;
    localparam int unsigned LSEL_IDX_MSB = 7;

    // Register select codes on the control-register move port
    localparam logic SEL_CTRL = 1'h0;
    localparam logic SEL_LINE = 1'h1;

    // Reset values
    localparam logic             ENABLE_RST = 1'h0;
    localparam logic             FREEZE_RST = 1'h0;
    localparam logic [IDX_W-1:0] LSEL_RST   = 6'h00;

    typedef enum logic {
        ST_IDLE,
        ST_EXT
    } dic_state_e;

    typedef struct packed {
        logic [31:0] addr;
        logic        space_bit2;
        logic        is_instr;
    } dic_fetch_s;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic [15:0] word;
    } dic_rsp_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        sel;
        logic        supervisor;
        logic [31:0] wdata;
    } dic_creg_s;

endpackage

// >>> dic_cache.sv
// What this block does
// - Direct-mapped, 64 entries of one long word
// - Entry holds address tag, space bit, valid, data
// - Fetch address bits 7..2 select the entry
// - Hit needs tag match and valid; bit 1 picks word
// - Miss fetches externally, fills entry unless frozen
// - Fill writes both words of the entry
// - Operand data accesses never cached
// - Reset clears valid bits, enable and freeze
// - Store-off pin forces cache disabled
// - Upper address bits always compared in tag
// - Control bits 31..4 read zero, writes ignored
// - Control bit 3 clears all valid bits
// - Control bit 2 clears selected entry only
// - Freeze bit 1 blocks replacement on miss
// - Enable bit 0; disabling keeps entries intact
// - Registers reachable only in supervisor mode
// - Stores opcode and extension word prefetches
// - Store-off pin does not invalidate entries
// - Line select bits 7..2 pick cleared entry
`timescale 1ns/1ps
module dic_cache (
    // Clock, reset, clock enable
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               ce_i,
    // Prefetch request and answer
    input  wire logic               fetch_req_i,
    input  wire dic_pkg::dic_fetch_s fetch_i,
    output logic                    fetch_ready_o,
    output dic_pkg::dic_rsp_s       fetch_rsp_o,
    // External long-word bus
    output logic                    ext_req_o,
    output logic [31:0]             ext_addr_o,
    input  wire logic               ext_ack_i,
    input  wire logic [31:0]        ext_data_i,
    // Control-register move port
    input  wire dic_pkg::dic_creg_s creg_i,
    output logic                    creg_rvalid_o,
    output logic [31:0]             creg_rdata_o,
    // Store-off pin, active low
    input  wire logic               store_off_pin_n_i
);

    dic_pkg::dic_state_e                 state_q;
    logic [dic_pkg::ENTRIES-1:0]         valid_q;
    logic [dic_pkg::TAG_W-1:0]           tag_q  [dic_pkg::ENTRIES];
    logic [31:0]                         data_q [dic_pkg::ENTRIES];
    logic                                enable_q;
    logic                                freeze_q;
    logic [dic_pkg::IDX_W-1:0]           lsel_q;
    dic_pkg::dic_fetch_s                 pend_q;
    logic                                ready_q;
    dic_pkg::dic_rsp_s                   rsp_q;
    logic                                ext_req_q;
    logic [31:0]                         ext_addr_q;
    logic                                rvalid_q;
    logic [31:0]                         rdata_q;

    logic                                en_eff;
    logic [dic_pkg::IDX_W-1:0]           req_idx;
    logic [dic_pkg::TAG_W-1:0]           req_tag;
    logic                                take;
    logic                                hit;
    logic [dic_pkg::IDX_W-1:0]           pend_idx;
    logic [dic_pkg::TAG_W-1:0]           pend_tag;
    logic                                done;
    logic                                fill;
    logic                                wr_ok;
    logic                                rd_ok;
    logic                                ctrl_wr;
    logic                                line_wr;
    logic                                clr_all;
    logic                                clr_one;
    logic [31:0]                         hit_data;

    // Cache usable only with enable set and the pin negated
    assign en_eff   = enable_q & store_off_pin_n_i;

    // Entry select and tag of the incoming fetch
    assign req_idx  = fetch_i.addr[dic_pkg::IDX_MSB:dic_pkg::IDX_LSB];
    assign req_tag  = {fetch_i.addr[31:dic_pkg::TAG_LSB], fetch_i.space_bit2};
    assign pend_idx = pend_q.addr[dic_pkg::IDX_MSB:dic_pkg::IDX_LSB];
    assign pend_tag = {pend_q.addr[31:dic_pkg::TAG_LSB], pend_q.space_bit2};
    assign hit_data = data_q[req_idx];

    assign take     = ready_q & fetch_req_i;
    // Only instruction fetches look up; data always bypasses
    assign hit      = en_eff & fetch_i.is_instr & valid_q[req_idx]
                      & (tag_q[req_idx] == req_tag);

    // External answer and fill decision
    assign done     = (state_q == dic_pkg::ST_EXT) & ext_ack_i;
    assign fill     = done & pend_q.is_instr & en_eff & ~freeze_q;

    // Register port decode
    assign wr_ok    = creg_i.wr & creg_i.supervisor;
    assign rd_ok    = creg_i.rd & creg_i.supervisor;
    assign ctrl_wr  = wr_ok & (creg_i.sel == dic_pkg::SEL_CTRL);
    assign line_wr  = wr_ok & (creg_i.sel == dic_pkg::SEL_LINE);
    assign clr_all  = ctrl_wr & creg_i.wdata[dic_pkg::CTRL_CLR_ALL_BIT];
    assign clr_one  = ctrl_wr & creg_i.wdata[dic_pkg::CTRL_CLR_ONE_BIT];

    // Fetch sequencing
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= dic_pkg::ST_IDLE;
            ready_q <= 1'h1;
        end else if (ce_i) begin
            unique case (state_q)
                dic_pkg::ST_IDLE: begin
                    if (take && !hit) begin
                        state_q <= dic_pkg::ST_EXT;
                        ready_q <= 1'h0;
                    end
                end
                dic_pkg::ST_EXT: begin
                    if (ext_ack_i) begin
                        state_q <= dic_pkg::ST_IDLE;
                        ready_q <= 1'h1;
                    end
                end
            endcase
        end
    end

    // Pending request held across the external access
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_q <= '0;
        end else if (ce_i && take && !hit) begin
            pend_q <= fetch_i;
        end
    end

    // External bus request, always long-word aligned
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_req_q  <= 1'h0;
            ext_addr_q <= 32'h0000_0000;
        end else if (ce_i) begin
            if (take && !hit) begin
                ext_req_q  <= 1'h1;
                ext_addr_q <= {fetch_i.addr[31:2], 2'h0};
            end else if (done) begin
                ext_req_q  <= 1'h0;
            end
        end
    end

    // Answer to the prefetch unit, one-cycle pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_q <= '0;
        end else if (ce_i) begin
            rsp_q.valid <= 1'h0;
            if (take && hit) begin
                rsp_q.valid <= 1'h1;
                rsp_q.hit   <= 1'h1;
                rsp_q.word  <= fetch_i.addr[dic_pkg::WSEL_BIT] ? hit_data[15:0]
                                                                : hit_data[31:16];
            end else if (done) begin
                rsp_q.valid <= 1'h1;
                rsp_q.hit   <= 1'h0;
                rsp_q.word  <= pend_q.addr[dic_pkg::WSEL_BIT] ? ext_data_i[15:0]
                                                               : ext_data_i[31:16];
            end
        end
    end

    // Valid bits; a fill in the same cycle as a clear wins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_q <= '0;
        end else if (ce_i) begin
            if (clr_all) begin
                valid_q <= '0;
            end else if (clr_one) begin
                valid_q[lsel_q] <= 1'h0;
            end
            if (fill) begin
                valid_q[pend_idx] <= 1'h1;
            end
        end
    end

    // Tag and data storage, no reset needed behind the valid bits
    always_ff @(posedge clk_i) begin
        if (ce_i && fill) begin
            tag_q[pend_idx]  <= pend_tag;
            data_q[pend_idx] <= ext_data_i;
        end
    end

    // Enable and freeze bits
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enable_q <= dic_pkg::ENABLE_RST;
            freeze_q <= dic_pkg::FREEZE_RST;
        end else if (ce_i && ctrl_wr) begin
            enable_q <= creg_i.wdata[dic_pkg::CTRL_ENABLE_BIT];
            freeze_q <= creg_i.wdata[dic_pkg::CTRL_FREEZE_BIT];
        end
    end

    // Line select index
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lsel_q <= dic_pkg::LSEL_RST;
        end else if (ce_i && line_wr) begin
            lsel_q <= creg_i.wdata[dic_pkg::LSEL_IDX_MSB:dic_pkg::LSEL_IDX_LSB];
        end
    end

    // Register reads; clear bits and upper bits read zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_q <= 1'h0;
            rdata_q  <= 32'h0000_0000;
        end else if (ce_i) begin
            rvalid_q <= creg_i.rd;
            if (!rd_ok) begin
                rdata_q <= 32'h0000_0000;
            end else if (creg_i.sel == dic_pkg::SEL_CTRL) begin
                rdata_q <= {28'h0000000, 2'h0, freeze_q, enable_q};
            end else begin
                rdata_q <= {24'h000000, lsel_q, 2'h0};
            end
        end
    end

    assign fetch_ready_o = ready_q;
    assign fetch_rsp_o   = rsp_q;
    assign ext_req_o     = ext_req_q;
    assign ext_addr_o    = ext_addr_q;
    assign creg_rvalid_o = rvalid_q;
    assign creg_rdata_o  = rdata_q;

    // Checks
    hit_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && take && hit) |=> (rsp_q.valid && rsp_q.hit && !ext_req_q))
        else $error("hit not answered next cycle");

    miss_external_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && take && !hit) |=>
            (ext_req_q && ext_addr_q[31:2] == $past(fetch_i.addr[31:2])
             && ext_addr_q[1:0] == 2'h0 && !ready_q))
        else $error("miss did not start aligned external fetch");

    fill_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && fill) |=>
            (valid_q[$past(pend_idx)] && data_q[$past(pend_idx)] == $past(ext_data_i)))
        else $error("fill did not store long word");

    freeze_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && done && freeze_q && !valid_q[pend_idx]) |=> !valid_q[$past(pend_idx)])
        else $error("frozen cache replaced entry");

    data_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && take && !fetch_i.is_instr) |=> (ext_req_q && !rsp_q.valid && !ready_q))
        else $error("operand access used the cache");

    pin_disable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && take && !store_off_pin_n_i) |=> (ext_req_q && !rsp_q.valid))
        else $error("store-off pin did not force external fetch");

    pin_keeps_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !store_off_pin_n_i && !clr_all && !clr_one) |=>
            ((valid_q & ~$past(valid_q)) == '0 && $past(valid_q) == valid_q))
        else $error("store-off pin changed entries");

    clear_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && clr_all && !fill) |=> (valid_q == '0))
        else $error("clear all left a valid entry");

    clear_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && clr_one && !clr_all && !fill) |=>
            (!valid_q[$past(lsel_q)]
             && (valid_q | (64'h1 << $past(lsel_q))) == ($past(valid_q) | (64'h1 << $past(lsel_q)))))
        else $error("clear entry touched the wrong entry");

    reset_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> (valid_q == '0 && !enable_q && !freeze_q))
        else $error("reset left cache state");

    ctrl_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && rd_ok && creg_i.sel == dic_pkg::SEL_CTRL) |=>
            (rvalid_q && rdata_q[31:2] == 30'h0 && rdata_q[0] == $past(enable_q)))
        else $error("control read showed reserved or clear bits");

    user_blocked_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && creg_i.wr && !creg_i.supervisor) |=>
            (enable_q == $past(enable_q) && freeze_q == $past(freeze_q)))
        else $error("user mode changed control bits");

    miss_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && done) |=> (rsp_q.valid && !rsp_q.hit && !ext_req_q && ready_q))
        else $error("external answer not passed on");

    word_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && take && hit) |=>
            (rsp_q.word == ($past(fetch_i.addr[dic_pkg::WSEL_BIT])
                            ? data_q[$past(req_idx)][15:0]
                            : data_q[$past(req_idx)][31:16])))
        else $error("hit returned the wrong word");

    tag_stored_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && fill) |=> (tag_q[$past(pend_idx)] == $past(pend_tag)))
        else $error("fill did not store the tag");

    data_no_fill_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && done && !pend_q.is_instr && !clr_all && !clr_one) |=>
            (rsp_q.valid && !rsp_q.hit && valid_q == $past(valid_q)))
        else $error("operand access filled an entry");

    off_no_fill_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !en_eff && !clr_all && !clr_one) |=> (valid_q == $past(valid_q)))
        else $error("disabled cache changed an entry");

    off_external_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && take && !en_eff) |=> (ext_req_q && !rsp_q.valid))
        else $error("disabled cache answered from the array");

    frozen_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && done && freeze_q) |=> (data_q[$past(pend_idx)] == $past(data_q[pend_idx])))
        else $error("frozen cache replaced entry data");

    freeze_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && rd_ok && creg_i.sel == dic_pkg::SEL_CTRL) |=>
            (rdata_q[1] == $past(freeze_q)))
        else $error("control read lost the freeze bit");

    line_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && rd_ok && creg_i.sel == dic_pkg::SEL_LINE) |=>
            (rvalid_q && rdata_q == {24'h000000, $past(lsel_q), 2'h0}))
        else $error("line select read wrong");

    user_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && creg_i.rd && !creg_i.supervisor) |=> (rvalid_q && rdata_q == 32'h0000_0000))
        else $error("user mode read showed a register");

    line_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && line_wr) |=>
            (lsel_q == $past(creg_i.wdata[dic_pkg::LSEL_IDX_MSB:dic_pkg::LSEL_IDX_LSB])))
        else $error("line select write lost");

    ctrl_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && ctrl_wr) |=>
            (enable_q == $past(creg_i.wdata[dic_pkg::CTRL_ENABLE_BIT])
             && freeze_q == $past(creg_i.wdata[dic_pkg::CTRL_FREEZE_BIT])))
        else $error("control write lost");

endmodule

// >>> dic_ext_mem.sv
`timescale 1ns/1ps
// External long-word memory on the far side of the fill port
module dic_ext_mem (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Fill request from the cache
    input  wire logic        ext_req_i,
    input  wire logic [31:0] ext_addr_i,
    // Content pattern and wait states
    input  wire logic [31:0] salt_i,
    input  wire logic [3:0]  lat_i,
    // Answer
    output logic             ext_ack_o,
    output logic [31:0]      ext_data_o
);
    logic [3:0]  cnt_q;
    logic [31:0] val_q;

    // Data is only meaningful with the acknowledge; inverted otherwise
    assign ext_data_o = ext_ack_o ? val_q : ~val_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_ack_o <= 1'h0;
            cnt_q     <= 4'h0;
            val_q     <= 32'h0;
        end else if (ext_ack_o || !ext_req_i) begin
            ext_ack_o <= 1'h0;
            cnt_q     <= 4'h0;
        end else if (cnt_q == lat_i) begin
            ext_ack_o <= 1'h1;
            val_q     <= ext_addr_i ^ salt_i;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// >>> dic_cache_tb.sv
`timescale 1ns/1ps
module dic_cache_tb;
    localparam logic [31:0] S1 = 32'h1111_0000;
    localparam logic [31:0] S2 = 32'h2222_0000;
    localparam logic [31:0] S3 = 32'h3333_0000;
    localparam logic [31:0] A  = 32'hff00_1004;
    localparam logic [31:0] B  = 32'h0000_2008;
    localparam logic        CR = dic_pkg::SEL_CTRL;
    localparam logic        LR = dic_pkg::SEL_LINE;

    logic                clk_i, rst_i, ce_i, fetch_req_i, fetch_ready_o;
    logic                ext_req_o, ext_ack_i, creg_rvalid_o, store_off_pin_n_i;
    dic_pkg::dic_fetch_s fetch_i;
    dic_pkg::dic_rsp_s   fetch_rsp_o;
    dic_pkg::dic_creg_s  creg_i;
    logic [31:0]         ext_addr_o, ext_data_i, creg_rdata_o, salt;
    logic [3:0]          lat;
    int                  miscompares = 0;
    int                  cmp_count = 0;
    int                  acks = 0;
    int                  cyc = 0;

    dic_cache dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .fetch_req_i(fetch_req_i),
        .fetch_i(fetch_i), .fetch_ready_o(fetch_ready_o), .fetch_rsp_o(fetch_rsp_o),
        .ext_req_o(ext_req_o), .ext_addr_o(ext_addr_o), .ext_ack_i(ext_ack_i),
        .ext_data_i(ext_data_i), .creg_i(creg_i), .creg_rvalid_o(creg_rvalid_o),
        .creg_rdata_o(creg_rdata_o), .store_off_pin_n_i(store_off_pin_n_i));

    dic_ext_mem mem (.clk_i(clk_i), .rst_i(rst_i), .ext_req_i(ext_req_o),
        .ext_addr_i(ext_addr_o), .salt_i(salt), .lat_i(lat), .ext_ack_o(ext_ack_i),
        .ext_data_o(ext_data_i));

    initial begin
        clk_i = 1'h0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        if (ext_ack_i && ext_req_o) acks++;
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            end_sim;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cw(input logic sel, input logic sup, input logic [31:0] d);
        @(negedge clk_i);
        creg_i = {1'h1, 1'h0, sel, sup, d};
        @(negedge clk_i);
        creg_i.wr = 1'h0;
    endtask

    task automatic cr(input logic sel, input logic sup, input logic [31:0] exp);
        @(negedge clk_i);
        creg_i = {1'h0, 1'h1, sel, sup, 32'h0};
        @(negedge clk_i);
        creg_i.rd = 1'h0;
        chk("rvalid", 32'h1, {31'h0, creg_rvalid_o});
        chk("rdata", exp, creg_rdata_o);
    endtask

    // Fetch one word; s is the memory pattern the expected word was filled with
    task automatic ft(input logic [31:0] a, input logic sp, ins, eh, input logic [31:0] s);
        logic [31:0] d;
        int          a0;
        int          n;
        d  = {a[31:2], 2'h0} ^ s;
        a0 = acks;
        n  = 0;
        @(negedge clk_i);
        fetch_req_i = 1'h1;
        fetch_i     = {a, sp, ins};
        @(negedge clk_i);
        fetch_req_i = 1'h0;
        while (fetch_rsp_o.valid !== 1'h1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk("valid", 32'h1, {31'h0, fetch_rsp_o.valid});
        chk("hit", {31'h0, eh}, {31'h0, fetch_rsp_o.hit});
        chk("word", {16'h0, a[1] ? d[15:0] : d[31:16]}, {16'h0, fetch_rsp_o.word});
        chk("bus", {31'h0, !eh}, 32'(acks - a0));
        chk("ext_req", 32'h0, {31'h0, ext_req_o});
        if (eh) chk("delay", 32'h0, 32'(n));
        else chk("addr", {a[31:2], 2'h0}, ext_addr_o);
    endtask

    task automatic t_reset;
        chk("ready", 32'h1, {31'h0, fetch_ready_o});
        chk("ext_req", 32'h0, {31'h0, ext_req_o});
        cr(CR, 1'h1, 32'h0);
        cr(LR, 1'h1, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_regs;
        cw(CR, 1'h1, 32'hffff_fff3);
        cr(CR, 1'h1, 32'h3);
        cw(CR, 1'h0, 32'h0);
        cr(CR, 1'h1, 32'h3);
        cr(CR, 1'h0, 32'h0);
        cw(LR, 1'h1, 32'hffff_ffff);
        cr(LR, 1'h1, 32'hfc);
        cw(CR, 1'h1, 32'h1);
        $display("test regs done");
    endtask

    task automatic t_fill;
        lat  = 4'h6;
        salt = S1;
        ft(32'h0000_1004, 1'h0, 1'h1, 1'h0, S1);
        lat = 4'h1;
        ft(32'h0000_1006, 1'h0, 1'h1, 1'h1, S1);
        salt = S2;
        ft(32'h0000_1004, 1'h0, 1'h1, 1'h1, S1);
        ft(A, 1'h0, 1'h1, 1'h0, S2);
        ft(A | 32'h2, 1'h0, 1'h1, 1'h1, S2);
        ft(A, 1'h1, 1'h1, 1'h0, S2);
        $display("test fill done");
    endtask

    task automatic t_data;
        salt = S3;
        ft(B, 1'h0, 1'h0, 1'h0, S3);
        ft(B, 1'h0, 1'h1, 1'h0, S3);
        ft(B, 1'h0, 1'h0, 1'h0, S3);
        ft(B, 1'h0, 1'h1, 1'h1, S3);
        cw(CR, 1'h1, 32'h3);
        salt = S1;
        ft(B, 1'h1, 1'h1, 1'h0, S1);
        ft(B, 1'h0, 1'h1, 1'h1, S3);
        cw(CR, 1'h1, 32'h1);
        $display("test data and freeze done");
    endtask

    task automatic t_off;
        cw(CR, 1'h1, 32'h0);
        ft(B, 1'h0, 1'h1, 1'h0, S1);
        cw(CR, 1'h1, 32'h1);
        ft(B, 1'h0, 1'h1, 1'h1, S3);
        store_off_pin_n_i = 1'h0;
        ft(B, 1'h0, 1'h1, 1'h0, S1);
        store_off_pin_n_i = 1'h1;
        ft(B, 1'h0, 1'h1, 1'h1, S3);
        $display("test disable done");
    endtask

    task automatic t_hold;
        ce_i = 1'h0;
        cw(CR, 1'h1, 32'h0);
        ce_i = 1'h1;
        cr(CR, 1'h1, 32'h1);
        $display("test clock enable done");
    endtask

    task automatic t_clear;
        cw(LR, 1'h1, 32'h04);
        cw(CR, 1'h1, 32'h5);
        cr(CR, 1'h1, 32'h1);
        ft(A, 1'h1, 1'h1, 1'h0, S1);
        ft(B, 1'h0, 1'h1, 1'h1, S3);
        cw(CR, 1'h1, 32'h9);
        cr(CR, 1'h1, 32'h1);
        ft(B, 1'h0, 1'h1, 1'h0, S1);
        ft(A, 1'h1, 1'h1, 1'h0, S1);
        cw(CR, 1'h1, 32'h4);
        cw(CR, 1'h1, 32'h1);
        ft(A | 32'h2, 1'h1, 1'h1, 1'h0, S1);
        $display("test clear done");
    endtask

    task automatic t_rst2;
        ft(B, 1'h0, 1'h1, 1'h1, S1);
        @(negedge clk_i);
        rst_i = 1'h1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'h0;
        cr(CR, 1'h1, 32'h0);
        cw(CR, 1'h1, 32'h1);
        ft(B, 1'h0, 1'h1, 1'h0, S1);
        $display("test second reset done");
    endtask

    initial begin
        rst_i             = 1'h1;
        ce_i              = 1'h1;
        fetch_req_i       = 1'h0;
        fetch_i           = '0;
        creg_i            = '0;
        store_off_pin_n_i = 1'h1;
        salt              = S1;
        lat               = 4'h1;
        repeat (16) @(negedge clk_i);
        rst_i = 1'h0;
        t_reset;
        t_regs;
        t_fill;
        t_data;
        t_off;
        t_hold;
        t_clear;
        t_rst2;
        end_sim;
    end
endmodule
